// ---- verilog/nsync_defines.svh ----
`ifndef NSYNC_DEFINES_SVH
`define NSYNC_DEFINES_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define NSYNC_IDX_OSC_CONTROL      12'h0300
`define NSYNC_IDX_SYNC_SOURCE_CFG  12'h0302
`define NSYNC_IDX_ACCUM_RESET_MASK 12'h0303
`define NSYNC_IDX_SOFT_TRIGGER     12'h0304
`define NSYNC_IDX_SYNC_STATUS      12'h0306

// ==========================================================================
// Reset values
// ==========================================================================
`define NSYNC_RST_OSC_CONTROL      8'h00
`define NSYNC_RST_SYNC_SOURCE_CFG  8'h00
`define NSYNC_RST_ACCUM_RESET_MASK 8'h0f
`define NSYNC_RST_SOFT_TRIGGER     8'h00

// ==========================================================================
// Field positions
// ==========================================================================
`define NSYNC_FAST_RECONFIG_ENABLE_BIT 7
`define NSYNC_SYNC_SOURCE_SELECT_LSB   0
`define NSYNC_SOFT_TRIGGER_BIT         0
`define NSYNC_STATUS_ARMED_BIT         0
`define NSYNC_STATUS_MARKER_WAIT_BIT   1
`define NSYNC_STATUS_FAST_SELECT_BIT   2

// ==========================================================================
// Marker timing, in samples
// ==========================================================================
`define NSYNC_MARKER_LOW_MIN   4
`define NSYNC_MARKER_HIGH_RUN  4

`endif

// ---- verilog/nsync_pkg.sv ----
`default_nettype none

package nsync_pkg;

    typedef enum logic [1:0] {
        NSYNC_SRC_IMMEDIATE   = 2'b00,
        NSYNC_SRC_NEXT_SYSREF = 2'b01,
        NSYNC_SRC_EACH_SYSREF = 2'b10,
        NSYNC_SRC_LSB_MARKER  = 2'b11
    } nsync_source_e;

endpackage : nsync_pkg

`default_nettype wire

// ---- verilog/nsync_edge_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module nsync_edge_sync
#(
    parameter logic RESET_LEVEL = 1'b0
)
(
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic sig_i,
    output logic      level_o,
    output logic      rise_o
);

    logic meta;
    logic stable;
    logic last;

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            meta   <= RESET_LEVEL;
            stable <= RESET_LEVEL;
            last   <= RESET_LEVEL;
        end
        else
        begin
            meta   <= sig_i;
            stable <= meta;
            last   <= stable;
        end
    end

    assign level_o = stable;
    assign rise_o  = stable & ~last;

endmodule : nsync_edge_sync

`default_nettype wire

// ---- verilog/nsync_marker_detect.sv ----
`timescale 1ns/10ps
`default_nettype none

`include "nsync_defines.svh"

module nsync_marker_detect
(
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic enable_i,
    input  wire logic valid_i,
    input  wire logic lsb_i,
    output logic      hit_o
);

    logic [2:0] low_cnt;
    logic [2:0] high_cnt;
    logic [2:0] next_low_cnt;
    logic [2:0] next_high_cnt;

    wire  low_done = (low_cnt >= 3'(`NSYNC_MARKER_LOW_MIN));
    wire  last_high = (high_cnt == 3'(`NSYNC_MARKER_HIGH_RUN - 1));

    // Hit on the fourth high sample itself, same cycle
    assign hit_o = enable_i & valid_i & lsb_i & low_done & last_high;

    always_comb
    begin
        next_low_cnt  = low_cnt;
        next_high_cnt = high_cnt;
        if (!enable_i || hit_o)
        begin
            next_low_cnt  = 3'h0;
            next_high_cnt = 3'h0;
        end
        else if (valid_i && !lsb_i)
        begin
            next_high_cnt = 3'h0;
            if (high_cnt != 3'h0)
                next_low_cnt = 3'h1;
            else if (!low_done)
                next_low_cnt = low_cnt + 3'h1;
        end
        else if (valid_i && lsb_i)
        begin
            if (low_done)
                next_high_cnt = high_cnt + 3'h1;
            else
                next_low_cnt = 3'h0;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            low_cnt  <= 3'h0;
            high_cnt <= 3'h0;
        end
        else
        begin
            low_cnt  <= next_low_cnt;
            high_cnt <= next_high_cnt;
        end
    end

endmodule : nsync_marker_detect

`default_nettype wire

// ---- verilog/nsync_trigger.sv ----
// Operation
// (RULE1) Normal mode: event applies masked resets and pending dither, frequency, phase.
// (RULE2) Source 0, normal: trigger bit set fires all events in one cycle.
// (RULE3) Source 1, normal: trigger bit set arms one event at next SYSREF rise.
// (RULE4) Source 2, normal: event on every SYSREF rise while trigger bit high.
// (RULE5) Source 3, trigger high: detect four lows then four highs on I LSb.
// (RULE6) Marker event coincides with the fourth high sample at the input.
// (RULE7) Fast mode: events apply fast reset mask and fast oscillator values.
// (RULE8) Fast mode, source 0, sync flag: events at chip select rising edge.
// (RULE9) Fast mode, source 3, sync flag: after chip select rise, await marker.
// (RULE10) While awaiting fast-mode marker, the I LSb is forced to zero.
// (RULE11) After the fourth high marker sample the LSb is data again.
// (RULE12) Host changes source select only with trigger low, fast port idle.
// (RULE13) Accumulator reset mask resets to low four bits set.
// (RULE14) Fast enable selects fast registers over normal oscillator settings.
// (RULE15) Writing one over zero fires bound events; read returns last write.
// (RULE16) Each set mask bit resets its oscillator accumulator on every event.
// (RULE17) Fast mode, source 1 or 2: no events at all.
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

`include "nsync_defines.svh"

module nsync_trigger
#(
    parameter int NUM_OSC      = 4,
    parameter int SAMPLE_WIDTH = 16
)
(
    input  wire logic                    CLK_SYS_I,
    input  wire logic                    ARST_N_I,
    input  wire logic                    PSEL_I,
    input  wire logic                    PENABLE_I,
    input  wire logic                    PWRITE_I,
    input  wire logic [11:0]             PADDR_I,
    input  wire logic [31:0]             PWDATA_I,
    output logic      [31:0]             PRDATA_O,
    output logic                         PREADY_O,
    output logic                         PSLVERR_O,
    input  wire logic                    SYSREF_I,
    input  wire logic                    FAST_PORT_CHIP_SELECT_I,
    input  wire logic                    FAST_SYNC_FLAG_I,
    input  wire logic [NUM_OSC-1:0]      FAST_ACCUM_RESET_MASK_I,
    input  wire logic                    SAMPLE_VALID_I,
    input  wire logic [SAMPLE_WIDTH-1:0] SAMPLE_I,
    output logic                         SAMPLE_VALID_O,
    output logic      [SAMPLE_WIDTH-1:0] SAMPLE_O,
    output logic                         SYNC_EVENT_O,
    output logic      [NUM_OSC-1:0]      ACCUM_RESET_O,
    output logic                         FAST_SELECT_O
);

    // ======================================================================
    // Elaboration checks
    // ======================================================================
    if (NUM_OSC < 1 || NUM_OSC > 4)
    begin : g_bad_osc
        $error("NUM_OSC must lie between 1 and 4");
    end
    if (SAMPLE_WIDTH < 2)
    begin : g_bad_width
        $error("SAMPLE_WIDTH must be at least 2");
    end

    // ======================================================================
    // Helpers
    // ======================================================================
    function automatic logic [11:0] byte_addr(input logic [11:0] idx);
        byte_addr = 12'(idx << 2);
    endfunction : byte_addr

    function automatic logic [31:0] widen(input logic [7:0] val);
        widen = {24'h0000_00, val};
    endfunction : widen

    // ======================================================================
    // Register storage
    // ======================================================================
    logic [7:0] osc_control;
    logic [7:0] oscillator_sync_source_config;
    logic [7:0] oscillator_accumulator_reset_mask;
    logic [7:0] soft_trigger;

    // ======================================================================
    // Synchronised pins
    // ======================================================================
    logic sysref_rise;
    logic cs_rise;

    nsync_edge_sync u_sysref_sync
    (
        .clk_i    (CLK_SYS_I),
        .arst_n_i (ARST_N_I),
        .sig_i    (SYSREF_I),
        .level_o  (),
        .rise_o   (sysref_rise)
    );

    nsync_edge_sync #(.RESET_LEVEL(1'b1)) u_cs_sync
    (
        .clk_i    (CLK_SYS_I),
        .arst_n_i (ARST_N_I),
        .sig_i    (FAST_PORT_CHIP_SELECT_I),
        .level_o  (),
        .rise_o   (cs_rise)
    );

    // ======================================================================
    // APB decode
    // ======================================================================
    wire setup_phase = PSEL_I & ~PENABLE_I;
    wire write_take  = PSEL_I & PENABLE_I & PREADY_O & PWRITE_I;

    wire hit_ctrl   = (PADDR_I == byte_addr(`NSYNC_IDX_OSC_CONTROL));
    wire hit_src    = (PADDR_I == byte_addr(`NSYNC_IDX_SYNC_SOURCE_CFG));
    wire hit_mask   = (PADDR_I == byte_addr(`NSYNC_IDX_ACCUM_RESET_MASK));
    wire hit_trig   = (PADDR_I == byte_addr(`NSYNC_IDX_SOFT_TRIGGER));
    wire hit_status = (PADDR_I == byte_addr(`NSYNC_IDX_SYNC_STATUS));
    wire hit_any    = hit_ctrl | hit_src | hit_mask | hit_trig | hit_status;

    wire wr_ctrl = write_take & hit_ctrl;
    wire wr_src  = write_take & hit_src;
    wire wr_mask = write_take & hit_mask;
    wire wr_trig = write_take & hit_trig;

    // ======================================================================
    // Mode decode
    // ======================================================================
    wire fast_en = osc_control[`NSYNC_FAST_RECONFIG_ENABLE_BIT];
    wire trig_bit = soft_trigger[`NSYNC_SOFT_TRIGGER_BIT];

    nsync_pkg::nsync_source_e sync_source_select;
    assign sync_source_select = nsync_pkg::nsync_source_e'(
        oscillator_sync_source_config[`NSYNC_SYNC_SOURCE_SELECT_LSB +: 2]);

    wire src_imm  = (sync_source_select == nsync_pkg::NSYNC_SRC_IMMEDIATE);
    wire src_next = (sync_source_select == nsync_pkg::NSYNC_SRC_NEXT_SYSREF);
    wire src_each = (sync_source_select == nsync_pkg::NSYNC_SRC_EACH_SYSREF);
    wire src_mark = (sync_source_select == nsync_pkg::NSYNC_SRC_LSB_MARKER);

    // Rising write of the trigger bit
    wire trig_set = wr_trig & PWDATA_I[`NSYNC_SOFT_TRIGGER_BIT] & ~trig_bit; // (RULE15)

    // ======================================================================
    // Event sources
    // ======================================================================
    logic armed;
    logic fast_wait;
    logic marker_hit;

    wire norm_imm  = ~fast_en & src_imm & trig_set;                 // (RULE2)
    wire norm_next = ~fast_en & src_next & armed & sysref_rise;     // (RULE3)
    wire norm_each = ~fast_en & src_each & trig_bit & sysref_rise;  // (RULE4)
    wire norm_mark = ~fast_en & src_mark & trig_bit & marker_hit;   // (RULE5) (RULE6)

    // Flag is qualified on the chip select rise, fast port then idle
    wire fast_start = fast_en & cs_rise & FAST_SYNC_FLAG_I;
    wire fast_imm   = fast_start & src_imm;                         // (RULE8)
    wire fast_mark  = fast_wait & marker_hit;                       // (RULE9)
    // Codes 1 and 2 contribute no term in fast mode                // (RULE17)

    wire any_event = norm_imm | norm_next | norm_each | norm_mark
                   | fast_imm | fast_mark;

    wire marker_enable = (~fast_en & src_mark & trig_bit) | fast_wait; // (RULE5)

    // Mask source follows the fast enable
    wire [NUM_OSC-1:0] sel_mask = fast_en
        ? FAST_ACCUM_RESET_MASK_I                                   // (RULE7)
        : oscillator_accumulator_reset_mask[NUM_OSC-1:0];           // (RULE1)

    wire [SAMPLE_WIDTH-1:0] sample_fwd =
        {SAMPLE_I[SAMPLE_WIDTH-1:1], SAMPLE_I[0] & ~fast_wait};     // (RULE10)

    nsync_marker_detect u_marker
    (
        .clk_i    (CLK_SYS_I),
        .arst_n_i (ARST_N_I),
        .enable_i (marker_enable),
        .valid_i  (SAMPLE_VALID_I),
        .lsb_i    (SAMPLE_I[0]),
        .hit_o    (marker_hit)
    );

    // ======================================================================
    // Read mux
    // ======================================================================
    wire [7:0] status_byte = {5'h00, fast_en, fast_wait, armed};

    wire [31:0] read_word =
        hit_ctrl   ? widen(osc_control) :
        hit_src    ? widen(oscillator_sync_source_config) :
        hit_mask   ? widen(oscillator_accumulator_reset_mask) :
        hit_trig   ? widen(soft_trigger) :                          // (RULE15)
        hit_status ? widen(status_byte) :
                     32'h0000_0000;

    // ======================================================================
    // APB response
    // ======================================================================
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
            PRDATA_O  <= 32'h0000_0000;
        end
        else
        begin
            PREADY_O  <= setup_phase;
            PSLVERR_O <= setup_phase & ~hit_any;
            PRDATA_O  <= setup_phase ? read_word : 32'h0000_0000;
        end
    end

    // ======================================================================
    // Configuration registers
    // ======================================================================
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            osc_control                       <= `NSYNC_RST_OSC_CONTROL;
            oscillator_sync_source_config     <= `NSYNC_RST_SYNC_SOURCE_CFG;
            oscillator_accumulator_reset_mask <= `NSYNC_RST_ACCUM_RESET_MASK; // (RULE13)
            soft_trigger                      <= `NSYNC_RST_SOFT_TRIGGER;
        end
        else
        begin
            if (wr_ctrl)
                osc_control <= PWDATA_I[7:0];
            // Source may only change with trigger low and port idle  // (RULE12)
            if (wr_src)
                oscillator_sync_source_config <= PWDATA_I[7:0];
            if (wr_mask)
                oscillator_accumulator_reset_mask <= PWDATA_I[7:0];
            if (wr_trig)
                soft_trigger <= PWDATA_I[7:0];                      // (RULE15)
        end
    end

    // ======================================================================
    // One-shot arm for next SYSREF edge
    // ======================================================================
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            armed <= 1'b0;
        else if (fast_en || !src_next)
            armed <= 1'b0;
        else if (trig_set)
            armed <= 1'b1;                                          // (RULE3)
        else if (norm_next)
            armed <= 1'b0;
    end

    // ======================================================================
    // Fast-mode marker wait
    // ======================================================================
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
            fast_wait <= 1'b0;
        else if (!fast_en || !src_mark)
            fast_wait <= 1'b0;
        else if (fast_start)
            fast_wait <= 1'b1;                                      // (RULE9)
        else if (marker_hit)
            fast_wait <= 1'b0;                                      // (RULE11)
    end

    // ======================================================================
    // Outputs: event, resets and sample path share one register stage
    // ======================================================================
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            SYNC_EVENT_O   <= 1'b0;
            ACCUM_RESET_O  <= '0;
            FAST_SELECT_O  <= 1'b0;
            SAMPLE_VALID_O <= 1'b0;
            SAMPLE_O       <= '0;
        end
        else
        begin
            SYNC_EVENT_O   <= any_event;                            // (RULE1)
            ACCUM_RESET_O  <= any_event ? sel_mask : '0;            // (RULE16)
            FAST_SELECT_O  <= fast_en;                              // (RULE14)
            SAMPLE_VALID_O <= SAMPLE_VALID_I;
            SAMPLE_O       <= sample_fwd;                           // (RULE6)
        end
    end

endmodule : nsync_trigger

`default_nettype wire

// ---- bench/nsync_trigger_checker.sv ----
`timescale 1ns/10ps
`default_nettype none

module nsync_trigger_checker
#(
    parameter int NUM_OSC      = 4,
    parameter int SAMPLE_WIDTH = 16
)
(
    input wire logic                    CLK_SYS_I,
    input wire logic                    ARST_N_I,
    input wire logic                    PSEL_I,
    input wire logic                    PENABLE_I,
    input wire logic                    PWRITE_I,
    input wire logic [11:0]             PADDR_I,
    input wire logic [31:0]             PWDATA_I,
    input wire logic                    PREADY_O,
    input wire logic                    SYSREF_I,
    input wire logic [NUM_OSC-1:0]      FAST_ACCUM_RESET_MASK_I,
    input wire logic [SAMPLE_WIDTH-1:0] SAMPLE_I,
    input wire logic                    SAMPLE_VALID_O,
    input wire logic [SAMPLE_WIDTH-1:0] SAMPLE_O,
    input wire logic                    SYNC_EVENT_O,
    input wire logic [NUM_OSC-1:0]      ACCUM_RESET_O,
    input wire logic                    FAST_SELECT_O
);
    // ====
    // Register shadows
    logic       wr;
    logic [7:0] mask;
    logic [1:0] src;
    logic       fast;
    logic       trig;

    assign wr = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I;

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I)
    begin
        if (!ARST_N_I)
        begin
            mask <= 8'h0f;
            src  <= 2'h0;
            fast <= 1'b0;
            trig <= 1'b0;
        end
        else if (wr)
        begin
            if (PADDR_I == 12'h0c0c) mask <= PWDATA_I[7:0];
            if (PADDR_I == 12'h0c08) src <= PWDATA_I[1:0];
            if (PADDR_I == 12'h0c00) fast <= PWDATA_I[7];
            if (PADDR_I == 12'h0c10) trig <= PWDATA_I[0];
        end
    end

    // ====
    // Properties
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);

    AST_PREADY_AFTER_SETUP: assert property (PSEL_I && !PENABLE_I |=> PREADY_O)
        else $error("no answer after setup");
    AST_RESET_ONLY_ON_EVENT: assert property (!SYNC_EVENT_O |-> ACCUM_RESET_O == '0)
        else $error("reset outside event");
    AST_NORMAL_MASK: assert property (SYNC_EVENT_O && !fast && !FAST_SELECT_O
        |-> ACCUM_RESET_O == mask[NUM_OSC-1:0]) else $error("normal mask");
    AST_FAST_MASK: assert property (SYNC_EVENT_O && fast && FAST_SELECT_O
        |-> ACCUM_RESET_O == $past(FAST_ACCUM_RESET_MASK_I))
        else $error("fast mask");
    AST_FAST_RESERVED: assert property (fast && FAST_SELECT_O && src[0] != src[1]
        |-> !SYNC_EVENT_O) else $error("event on reserved code");
    AST_SOFT_NOW: assert property (wr && PADDR_I == 12'h0c10 && PWDATA_I[0]
        && !trig && src == 2'h0 && !fast |=> SYNC_EVENT_O) else $error("soft");
    AST_EACH_SYSREF: assert property (!fast && trig && src == 2'h2
        && $rose(SYSREF_I) |-> ##[3:5] SYNC_EVENT_O) else $error("sysref");
    AST_MARKER_ALIGN: assert property (SYNC_EVENT_O && !fast && src == 2'h3
        |-> SAMPLE_VALID_O && SAMPLE_O[0]) else $error("marker align");
    AST_SAMPLE_PASS: assert property (SAMPLE_O[SAMPLE_WIDTH-1:1]
        == $past(SAMPLE_I[SAMPLE_WIDTH-1:1])) else $error("sample path");

    cover property (SYNC_EVENT_O && src == 2'h3);
    cover property (SYNC_EVENT_O && fast);
    cover property (SYNC_EVENT_O && src == 2'h2);
endmodule : nsync_trigger_checker

bind nsync_trigger nsync_trigger_checker
    #(.NUM_OSC(NUM_OSC), .SAMPLE_WIDTH(SAMPLE_WIDTH)) u_checker
    (.CLK_SYS_I(CLK_SYS_I), .ARST_N_I(ARST_N_I), .PSEL_I(PSEL_I),
     .PENABLE_I(PENABLE_I), .PWRITE_I(PWRITE_I), .PADDR_I(PADDR_I),
     .PWDATA_I(PWDATA_I), .PREADY_O(PREADY_O), .SYSREF_I(SYSREF_I),
     .FAST_ACCUM_RESET_MASK_I(FAST_ACCUM_RESET_MASK_I),
     .SAMPLE_I(SAMPLE_I),
     .SAMPLE_VALID_O(SAMPLE_VALID_O), .SAMPLE_O(SAMPLE_O),
     .SYNC_EVENT_O(SYNC_EVENT_O), .ACCUM_RESET_O(ACCUM_RESET_O),
     .FAST_SELECT_O(FAST_SELECT_O));

`default_nettype wire

// ---- bench/nsync_host_model.sv ----
`timescale 1ns/10ps
`default_nettype none

module nsync_host_model
(
    input  wire logic        clk_i,
    output logic             sysref_o,
    output logic             cs_o,
    output logic             flag_o,
    output logic             valid_o,
    output logic [15:0]      sample_o
);
    initial
    begin
        sysref_o = 1'b0;
        cs_o     = 1'b1;
        flag_o   = 1'b0;
        valid_o  = 1'b0;
        sample_o = 16'h0000;
    end

    task automatic sysref_pulse();
        @(posedge clk_i);
        sysref_o <= 1'b1;
        repeat (4) @(posedge clk_i);
        sysref_o <= 1'b0;
        repeat (8) @(posedge clk_i);
    endtask : sysref_pulse

    // Source changes wait until the port is idle again
    task automatic frame(input logic sync);
        @(posedge clk_i);
        cs_o   <= 1'b0;
        flag_o <= sync;
        repeat (8) @(posedge clk_i);
        cs_o <= 1'b1;
        repeat (8) @(posedge clk_i);
        flag_o <= 1'b0;
    endtask : frame

    // Upper bits toggle; idle cycle after the run flips the lsb
    task automatic stream(input int n, input logic lsb);
        repeat (n)
        begin
            @(posedge clk_i);
            valid_o  <= 1'b1;
            sample_o <= {~sample_o[15:1], lsb};
        end
        @(posedge clk_i);
        valid_o  <= 1'b0;
        sample_o <= ~sample_o;
    endtask : stream
endmodule : nsync_host_model

`default_nettype wire

// ---- bench/nsync_trigger_tb.sv ----
`timescale 1ns/10ps
`default_nettype none

module nsync_trigger_tb;
    typedef struct packed
    {
        logic [11:0] a;
        logic [31:0] rst;
        logic [31:0] wv;
        logic        e;
    } nsync_row_s;

    logic        clk, arst_n, psel, penable, pwrite;
    logic        pready, pslverr, sysref, cs, flag, svi, svo, ev, fsel;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] si, so;
    logic [3:0]  fmask, acc, last_acc;
    logic        er;
    int          n_fail, n_compared, n_ev, n_hi, n0, h0;
    nsync_row_s  rows [5] = '{
        '{12'h0c00, 32'h0000_0000, 32'h0000_007c, 1'b0},
        '{12'h0c08, 32'h0000_0000, 32'h0000_00fc, 1'b0},
        '{12'h0c0c, 32'h0000_000f, 32'h0000_00a5, 1'b0},
        '{12'h0c10, 32'h0000_0000, 32'h0000_00fe, 1'b0},
        '{12'h0c40, 32'h0000_0000, 32'h0000_00ff, 1'b1}};

    nsync_trigger dut
    (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .PSEL_I(psel),
     .PENABLE_I(penable), .PWRITE_I(pwrite), .PADDR_I(paddr),
     .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready),
     .PSLVERR_O(pslverr), .SYSREF_I(sysref),
     .FAST_PORT_CHIP_SELECT_I(cs), .FAST_SYNC_FLAG_I(flag),
     .FAST_ACCUM_RESET_MASK_I(fmask), .SAMPLE_VALID_I(svi),
     .SAMPLE_I(si), .SAMPLE_VALID_O(svo), .SAMPLE_O(so),
     .SYNC_EVENT_O(ev), .ACCUM_RESET_O(acc), .FAST_SELECT_O(fsel));

    nsync_host_model host
    (.clk_i(clk), .sysref_o(sysref), .cs_o(cs), .flag_o(flag),
     .valid_o(svi), .sample_o(si));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    always @(posedge clk)
    begin
        if (ev === 1'b1) n_ev++;
        if (ev === 1'b1) last_acc = acc;
        if (svo === 1'b1 && so[0] === 1'b1) n_hi++;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int t;
        t = 0;
        @(posedge clk);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            t++;
        end
        while (pready !== 1'b1 && t < 50);
        rd = prdata;
        er = pslverr;
        chk("pready", pready, 1'b1);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task automatic complete_run();
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        complete_run();
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        fmask  = 4'h9;
        arst_n = 1'b0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        foreach (rows[i])
        begin
            apb(1'b0, rows[i].a, 32'h0000_0000);
            chk("reset value", rd, rows[i].rst);
            chk("slverr", er, rows[i].e);
            wr(rows[i].a, rows[i].wv);
            apb(1'b0, rows[i].a, 32'h0000_0000);
            chk("readback", rd, rows[i].e ? 32'h0 : rows[i].wv);
        end
        $display("register table done");
        wr(12'h0c0c, 32'h0000_0005);
        n0 = n_ev;
        wr(12'h0c10, 32'h0000_0001);
        wr(12'h0c10, 32'h0000_0001);
        repeat (3) @(posedge clk);
        chk("immediate count", n_ev - n0, 1);
        chk("immediate mask", last_acc, 4'h5);
        apb(1'b0, 12'h0c10, 32'h0000_0000);
        chk("trigger readback", rd, 32'h0000_0001);
        $display("immediate done");
        wr(12'h0c10, 32'h0000_0000);
        wr(12'h0c08, 32'h0000_0001);
        n0 = n_ev;
        wr(12'h0c10, 32'h0000_0001);
        repeat (8) @(posedge clk);
        chk("armed early", n_ev - n0, 0);
        host.sysref_pulse();
        host.sysref_pulse();
        chk("next sysref", n_ev - n0, 1);
        $display("next sysref done");
        wr(12'h0c10, 32'h0000_0000);
        wr(12'h0c08, 32'h0000_0002);
        n0 = n_ev;
        wr(12'h0c10, 32'h0000_0001);
        repeat (3) host.sysref_pulse();
        wr(12'h0c10, 32'h0000_0000);
        host.sysref_pulse();
        chk("each sysref", n_ev - n0, 3);
        $display("each sysref done");
        wr(12'h0c08, 32'h0000_0003);
        n0 = n_ev;
        h0 = n_hi;
        wr(12'h0c10, 32'h0000_0001);
        host.stream(4, 1'b0);
        host.stream(3, 1'b1);
        host.stream(1, 1'b0);
        host.stream(4, 1'b1);
        host.stream(4, 1'b0);
        host.stream(4, 1'b1);
        repeat (3) @(posedge clk);
        chk("marker count", n_ev - n0, 1);
        chk("marker lsb kept", n_hi - h0, 11);
        wr(12'h0c10, 32'h0000_0000);
        $display("normal marker done");
        wr(12'h0c08, 32'h0000_0000);
        wr(12'h0c00, 32'h0000_0080);
        n0 = n_ev;
        wr(12'h0c10, 32'h0000_0001);
        wr(12'h0c10, 32'h0000_0000);
        host.frame(1'b0);
        chk("fast no flag", n_ev - n0, 0);
        host.frame(1'b1);
        chk("fast flag", n_ev - n0, 1);
        chk("fast mask", last_acc, 4'h9);
        chk("fast select", fsel, 1'b1);
        for (int c = 1; c < 3; c++)
        begin
            wr(12'h0c08, 32'(c));
            host.frame(1'b1);
            host.sysref_pulse();
        end
        chk("reserved codes", n_ev - n0, 1);
        $display("fast source done");
        wr(12'h0c08, 32'h0000_0003);
        @(posedge clk);
        fmask <= 4'h6;
        h0 = n_hi;
        host.frame(1'b1);
        host.stream(4, 1'b0);
        host.stream(4, 1'b1);
        repeat (3) @(posedge clk);
        chk("fast marker", n_ev - n0, 2);
        chk("lsb zeroed", n_hi - h0, 0);
        chk("fast marker mask", last_acc, 4'h6);
        host.stream(1, 1'b1);
        repeat (3) @(posedge clk);
        chk("lsb data again", n_hi - h0, 1);
        $display("fast marker done");
        complete_run();
    end
endmodule : nsync_trigger_tb

`default_nettype wire
